/* File: fcr_floppy_cfg.sv */
// Floppy configuration register bank behind the indexed configuration port.
//
// Notes on behaviour
// - Defaults return only on power-on or hard bus reset, never on a soft reset.
// - Mode bit 0 picks normal mode when 0 and enhanced mode 2 when 1.
// - Mode bit 1 picks burst DMA when 0 and non-burst when 1, the default.
// - Mode bits 3:2 pick the interface variant, 11 the default AT one, 10 reserved.
// - Mode bit 4 set exchanges the drive 0 and drive 1 select and motor lines.
// - Mode bit 6 makes the drive outputs open drain when 0 and push-pull when 1.
// - Mode bit 7 set floats the four drive select and motor pins; the density output stays driven.
// - Write protect is either select gated by option bit 0, the input, or the disable bit.
// - Option bits 3:2 leave density normal for 00 and 01, force 1 for 10 and 0 for 11.
// - The type register holds drive A in bits 1:0, drive B in 3:2, spares above.
// - Index F3 reads as zero and ignores writes.
// - The host writes the index to the index port, then uses the data port next to it.
`include "fcr_consts.svh"
`default_nettype none
module fcr_floppy_cfg
  import fcr_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Configuration port
  input wire logic CFG_SEL_IN,
  input wire logic CFG_ADDR_IN,
  input wire logic CFG_WR_IN,
  input wire logic CFG_RD_IN,
  input wire logic [DATA_W-1:0] CFG_WDATA_IN,
  output logic [DATA_W-1:0] CFG_RDATA_OUT,
  // Core-side controls
  output logic ENH_MODE_OUT,
  output logic DMA_NON_BURST_OUT,
  output logic [1:0] IF_MODE_OUT,
  output logic [1:0] DRIVE_A_TYPE_OUT,
  output logic [1:0] DRIVE_B_TYPE_OUT,
  // Write protect inputs and result
  input wire logic WRITE_PROTECT_INPUT_IN,
  input wire logic DISABLE_WP_IN,
  output logic CORE_WRITE_PROTECT_OUT,
  // Density
  input wire logic CORE_DENSITY_IN,
  output logic DENSITY_OUT,
  // Drive lines from the core, active low
  input wire logic CORE_DRIVE0_SELECT_LINE_N_IN,
  input wire logic CORE_DRIVE1_SELECT_LINE_N_IN,
  input wire logic CORE_MOTOR0_ON_LINE_N_IN,
  input wire logic CORE_MOTOR1_ON_LINE_N_IN,
  // Drive pins: value, and enable low while driving
  output logic [3:0] DRIVE_PIN_OUT,
  output logic [3:0] DRIVE_PIN_OE_N_OUT
);
  // ==========================================
  // Index/data sequencing
  fcr_seq_t seq_reg, seq_next;
  logic [7:0] index_reg, index_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [DATA_W*3-1:0] all_regs;
  logic [DATA_W-1:0] store_rd;
  logic st_wr;
  logic [1:0] st_addr;
  logic [7:0] mode_r, opt_r, type_r;
  logic rd_pending_reg, rd_pending_next;

  initial begin
    if (DATA_W != 8) begin
      $error("fcr_floppy_cfg serves an eight-bit configuration port only.");
    end
  end

  // Map a register index to its store slot; 3 marks an index with no storage.
  function automatic logic [1:0] slot_of(input logic [7:0] idx);
    case (idx)
      `FCR_IDX_MODE: slot_of = 2'd0;
      `FCR_IDX_OPTION: slot_of = 2'd1;
      `FCR_IDX_TYPE: slot_of = 2'd2;
      default: slot_of = 2'd3;
    endcase
  endfunction : slot_of

  // Index capture, data write steering and read tracking.
  always_comb begin
    seq_next = seq_reg;
    index_next = index_reg;
    st_wr = 1'b0;
    st_addr = slot_of(index_reg);
    rd_pending_next = 1'b0;
    if (CFG_SEL_IN && CFG_WR_IN && CFG_ADDR_IN == `FCR_PORT_INDEX) begin
      index_next = CFG_WDATA_IN;
      seq_next = FCR_SEQ_INDEXED;
    end else if (CFG_SEL_IN && CFG_WR_IN && CFG_ADDR_IN == `FCR_PORT_DATA) begin
      st_wr = (seq_reg == FCR_SEQ_INDEXED) && (slot_of(index_reg) != 2'd3);
    end
    if (CFG_SEL_IN && CFG_RD_IN) begin
      rd_pending_next = 1'b1;
    end
  end

  // Read data: index port returns the index, data port the selected register.
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_pending_reg) begin
      rdata_next = (CFG_ADDR_IN == `FCR_PORT_INDEX) ? index_reg : store_rd;
    end
  end

  // Registering of the sequencing state; configuration reset is the hard reset.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      seq_reg <= FCR_SEQ_NO_INDEX;
      index_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rd_pending_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      index_reg <= index_next;
      rdata_reg <= rdata_next;
      rd_pending_reg <= rd_pending_next;
    end
  end

  assign CFG_RDATA_OUT = rdata_reg;

  // ==========================================
  // Register store
  fcr_reg_store #(
    .WIDTH(DATA_W),
    .DEPTH(3)
  ) u_store (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .wr_en_in(st_wr),
    .wr_addr_in(st_addr),
    .wr_data_in(CFG_WDATA_IN),
    .rd_addr_in(slot_of(index_next)),
    .rd_data_out(store_rd),
    .all_out(all_regs)
  );

  assign mode_r = all_regs[7:0];
  assign opt_r = all_regs[15:8];
  assign type_r = all_regs[23:16];

  // ==========================================
  // Control decode
  // Mode and type fields go straight to the core.
  assign ENH_MODE_OUT = mode_r[`FCR_MODE_ENH_BIT];
  assign DMA_NON_BURST_OUT = mode_r[`FCR_MODE_DMA_BIT];
  assign IF_MODE_OUT = mode_r[`FCR_MODE_IF_LSB +: 2];
  assign DRIVE_A_TYPE_OUT = type_r[1:0];
  assign DRIVE_B_TYPE_OUT = type_r[3:2];

  // Forced write protect; selects are active low, so a selected drive reads low.
  logic fwp;
  assign fwp = opt_r[`FCR_OPT_FWP_BIT];
  assign CORE_WRITE_PROTECT_OUT = (~CORE_DRIVE0_SELECT_LINE_N_IN & fwp)
    | (~CORE_DRIVE1_SELECT_LINE_N_IN & fwp) | WRITE_PROTECT_INPUT_IN | DISABLE_WP_IN;

  // Density override.
  fcr_density_t dens;
  assign dens = fcr_density_t'(opt_r[`FCR_OPT_DENS_LSB +: 2]);
  always_comb begin
    case (dens)
      FCR_DENS_ONE: DENSITY_OUT = 1'b1;
      FCR_DENS_ZERO: DENSITY_OUT = 1'b0;
      default: DENSITY_OUT = CORE_DENSITY_IN;
    endcase
  end

  // ==========================================
  // Drive pins: select 0, select 1, motor 0, motor 1
  logic swap;
  logic [3:0] line_n;
  assign swap = mode_r[`FCR_MODE_SWAP_BIT];
  assign line_n = swap ? {CORE_MOTOR0_ON_LINE_N_IN, CORE_MOTOR1_ON_LINE_N_IN,
                          CORE_DRIVE0_SELECT_LINE_N_IN, CORE_DRIVE1_SELECT_LINE_N_IN}
                       : {CORE_MOTOR1_ON_LINE_N_IN, CORE_MOTOR0_ON_LINE_N_IN,
                          CORE_DRIVE1_SELECT_LINE_N_IN, CORE_DRIVE0_SELECT_LINE_N_IN};

  // Open drain drives only lows; push-pull drives both levels; tristate drives nothing.
  generate
    for (genvar p = 0; p < 4; p++) begin : g_pin
      assign DRIVE_PIN_OUT[p] = line_n[p];
      assign DRIVE_PIN_OE_N_OUT[p] = mode_r[`FCR_MODE_TRI_BIT] ? 1'b1
        : (mode_r[`FCR_MODE_PP_BIT] ? 1'b0 : line_n[p]);
    end
  endgenerate

  // ==========================================
  // Checks
  a_tri_floats: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    mode_r[`FCR_MODE_TRI_BIT] |-> DRIVE_PIN_OE_N_OUT == 4'hF)
    else $error("Drive pins driven while tristated.");
  a_pp_drives: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode_r[7:6] == 2'b01) |-> DRIVE_PIN_OE_N_OUT == 4'h0)
    else $error("Push-pull pins not driven.");
  a_od_high: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (mode_r[7:6] == 2'b00) |-> DRIVE_PIN_OE_N_OUT == DRIVE_PIN_OUT)
    else $error("Open drain pin drives high.");
  a_swap_sel: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DRIVE_PIN_OUT[0] == (swap ? CORE_DRIVE1_SELECT_LINE_N_IN
                              : CORE_DRIVE0_SELECT_LINE_N_IN))
    else $error("Drive select exchange wrong.");
  a_wp_force: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (fwp && !CORE_DRIVE1_SELECT_LINE_N_IN) |-> CORE_WRITE_PROTECT_OUT)
    else $error("Forced write protect missing.");
  a_wp_idle: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!fwp && !WRITE_PROTECT_INPUT_IN && !DISABLE_WP_IN) |-> !CORE_WRITE_PROTECT_OUT)
    else $error("Write protect without cause.");
  a_dens_force: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    opt_r[3] |-> DENSITY_OUT == ~opt_r[2])
    else $error("Density override wrong.");
  a_mode_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (st_wr && st_addr == 2'd0) |=> mode_r == $past(CFG_WDATA_IN))
    else $error("Mode register not updated.");
  a_zero_read: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (CFG_SEL_IN && CFG_RD_IN && index_reg == `FCR_IDX_ZERO && CFG_ADDR_IN && !CFG_WR_IN)
    ##1 CFG_ADDR_IN |=> CFG_RDATA_OUT == 8'h00)
    else $error("Reserved index read nonzero.");
  a_reset_dflt: assert property (@(posedge CLK_IN)
    $past(SYS_RST_IN) |-> mode_r == `FCR_RST_MODE && type_r == `FCR_RST_TYPE)
    else $error("Defaults not restored.");
  a_dma_bit: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DMA_NON_BURST_OUT == mode_r[1] && IF_MODE_OUT == mode_r[3:2])
    else $error("Mode fields not decoded.");

  // ==========================================
  // Further checks on decode, steering and access sequencing
  // The mode output follows bit 0 of the stored mode byte.
  a_enh_bit: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    ENH_MODE_OUT == mode_r[0])
    else $error("Enhanced mode bit not decoded.");
  // The interface variant follows bits 3:2 of the stored mode byte.
  a_if_bits: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    IF_MODE_OUT == mode_r[3:2])
    else $error("Interface variant not decoded.");
  // The second select pin takes the other drive when exchanged.
  a_swap_sel1: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DRIVE_PIN_OUT[1] == (swap ? CORE_DRIVE0_SELECT_LINE_N_IN
                              : CORE_DRIVE1_SELECT_LINE_N_IN))
    else $error("Second select exchange wrong.");
  // The first motor pin takes the other motor line when exchanged.
  a_swap_mtr0: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DRIVE_PIN_OUT[2] == (swap ? CORE_MOTOR1_ON_LINE_N_IN
                              : CORE_MOTOR0_ON_LINE_N_IN))
    else $error("First motor exchange wrong.");
  // The second motor pin takes the other motor line when exchanged.
  a_swap_mtr1: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DRIVE_PIN_OUT[3] == (swap ? CORE_MOTOR0_ON_LINE_N_IN
                              : CORE_MOTOR1_ON_LINE_N_IN))
    else $error("Second motor exchange wrong.");
  // Forced protect also applies while drive 0 is selected.
  a_wp_force0: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (fwp && !CORE_DRIVE0_SELECT_LINE_N_IN) |-> CORE_WRITE_PROTECT_OUT)
    else $error("Forced write protect on drive 0 missing.");
  // The external protect input always reaches the core.
  a_wp_input: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    WRITE_PROTECT_INPUT_IN |-> CORE_WRITE_PROTECT_OUT)
    else $error("External write protect lost.");
  // The device disable protect bit always reaches the core.
  a_wp_disable: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DISABLE_WP_IN |-> CORE_WRITE_PROTECT_OUT)
    else $error("Disable write protect lost.");
  // Codes 00 and 01 pass the core density level through.
  a_dens_pass: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !opt_r[3] |-> DENSITY_OUT == CORE_DENSITY_IN)
    else $error("Density not passed through.");
  // Both drive type fields follow the low nibble of the type byte.
  a_type_fields: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    {DRIVE_B_TYPE_OUT, DRIVE_A_TYPE_OUT} == type_r[3:0])
    else $error("Drive type fields wrong.");
  // A data write to the type index lands in the type byte.
  a_type_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (CFG_SEL_IN && CFG_WR_IN && CFG_ADDR_IN && index_reg == `FCR_IDX_TYPE)
    |=> type_r == $past(CFG_WDATA_IN))
    else $error("Type register not updated.");
  // No write strobe ever reaches the store for an index without storage.
  a_zero_nowrite: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_wr |-> st_addr != 2'd3)
    else $error("Write to unstored index.");
  // A write to the index port captures the index.
  a_index_take: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (CFG_SEL_IN && CFG_WR_IN && !CFG_ADDR_IN) |=> index_reg == $past(CFG_WDATA_IN))
    else $error("Index not captured.");
  // No data write lands before any index has been written.
  a_seq_first: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (seq_reg == FCR_SEQ_NO_INDEX) |-> !st_wr)
    else $error("Data write without index.");
  // A read strobe is remembered for the following cycle.
  a_rd_track: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (CFG_SEL_IN && CFG_RD_IN) |=> rd_pending_reg)
    else $error("Read strobe lost.");
  // Read data hold when no read completes.
  a_rdata_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !rd_pending_reg |=> $stable(CFG_RDATA_OUT))
    else $error("Read data changed without a read.");
  // A data write to the option index lands in the option byte, spare bits too.
  a_opt_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (CFG_SEL_IN && CFG_WR_IN && CFG_ADDR_IN && index_reg == `FCR_IDX_OPTION)
    |=> opt_r == $past(CFG_WDATA_IN))
    else $error("Option register not updated.");
  // The option byte returns to its default on the hard reset.
  a_reset_opt: assert property (@(posedge CLK_IN)
    $past(SYS_RST_IN) |-> opt_r == `FCR_RST_OPTION)
    else $error("Option default not restored.");
  // Without a port access the stored mode byte never changes.
  a_idle_keep: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !CFG_SEL_IN |=> $stable(mode_r))
    else $error("Mode byte changed without access.");
endmodule : fcr_floppy_cfg
`default_nettype wire

/* File: fcr_consts.svh */
// Offsets, field positions, reset values and codes of the floppy configuration registers.
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH

// ==========================================
// Register indices
`define FCR_IDX_MODE 8'hF0
`define FCR_IDX_OPTION 8'hF1
`define FCR_IDX_TYPE 8'hF2
`define FCR_IDX_ZERO 8'hF3

// ==========================================
// Reset values
`define FCR_RST_MODE 8'h0E
`define FCR_RST_OPTION 8'h00
`define FCR_RST_TYPE 8'hFF
`define FCR_RST_ZERO 8'h00

// ==========================================
// Mode register fields
`define FCR_MODE_ENH_BIT 0
`define FCR_MODE_DMA_BIT 1
`define FCR_MODE_IF_LSB 2
`define FCR_MODE_SWAP_BIT 4
`define FCR_MODE_RSVD_BIT 5
`define FCR_MODE_PP_BIT 6
`define FCR_MODE_TRI_BIT 7

// ==========================================
// Option register fields
`define FCR_OPT_FWP_BIT 0
`define FCR_OPT_DENS_LSB 2

// ==========================================
// Port offsets within the configuration port pair
`define FCR_PORT_INDEX 1'b0
`define FCR_PORT_DATA 1'b1

`endif

/* File: fcr_pkg.sv */
// Types shared by the floppy configuration register bank.
`default_nettype none
package fcr_pkg;
  // Interface compatibility variants held in the mode register.
  typedef enum logic [1:0] {
    FCR_IF_ALT_B = 2'b00,
    FCR_IF_ALT_A = 2'b01,
    FCR_IF_RSVD = 2'b10,
    FCR_IF_AT = 2'b11
  } fcr_if_mode_t;

  // Density override codes held in the option register.
  typedef enum logic [1:0] {
    FCR_DENS_NORM = 2'b00,
    FCR_DENS_NORM_USER = 2'b01,
    FCR_DENS_ONE = 2'b10,
    FCR_DENS_ZERO = 2'b11
  } fcr_density_t;

  // Phase of the index/data access sequence.
  typedef enum logic {
    FCR_SEQ_NO_INDEX,
    FCR_SEQ_INDEXED
  } fcr_seq_t;
endpackage : fcr_pkg
`default_nettype wire

/* File: fcr_reg_store.sv */
// Small register store holding the writable configuration bytes, with a registered read port.
`include "fcr_consts.svh"
`default_nettype none
module fcr_reg_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read port
  input wire logic [1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out,
  // Whole contents for the control decode
  output logic [WIDTH*DEPTH-1:0] all_out
);
  // ==========================================
  // Storage
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_reg;
  logic [WIDTH-1:0] rd_next;
  localparam logic [WIDTH-1:0] RST_VAL [3] = '{`FCR_RST_MODE, `FCR_RST_OPTION, `FCR_RST_TYPE};

  initial begin
    if (WIDTH != 8 || DEPTH != 3) begin
      $error("fcr_reg_store serves eight-bit words and three entries only.");
    end
  end

  // Next contents and read data; unmapped read addresses give zero.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en_in && int'(wr_addr_in) < DEPTH) begin
      mem_next[wr_addr_in] = wr_data_in;
    end
    rd_next = (int'(rd_addr_in) < DEPTH) ? mem_next[rd_addr_in] : '0;
  end

  // Registering; only power-on or hard bus reset restores defaults.
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_reg[i] <= rst_in ? RST_VAL[i] : mem_next[i];
    end
    rd_reg <= rst_in ? '0 : rd_next;
  end

  assign rd_data_out = rd_reg;

  // Flatten the contents for the control decode.
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_flat
      assign all_out[g*WIDTH +: WIDTH] = mem_reg[g];
    end
  endgenerate
endmodule : fcr_reg_store
`default_nettype wire

/* File: fcr_host_model.sv */
// Host model driving the index and data ports of the floppy configuration registers.
`default_nettype none
module fcr_host_model (
  // Clock
  input wire logic clk_in,
  // Configuration port
  output logic sel_out,
  output logic addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // The port starts idle with no strobe raised.
  initial begin
    sel_out = 1'b0;
    addr_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // One write cycle on either port, launched at the falling edge.
  task automatic put(input logic a, input logic [7:0] d);
    @(negedge clk_in);
    sel_out = 1'b1;
    addr_out = a;
    wr_out = 1'b1;
    rd_out = 1'b0;
    wdata_out = d;
  endtask : put
  // Releases the port; the undriven data bus shows the inverse of its last value.
  task automatic idle();
    @(negedge clk_in);
    sel_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = ~wdata_out;
  endtask : idle
  // Index first, then data at the next address; mode bit 5 always goes out as zero.
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
    put(1'b0, idx);
    put(1'b1, (idx == 8'hF0) ? (val & 8'hDF) : val);
    idle();
    @(negedge clk_in);
  endtask : write_reg
  // Index write, then a data read held one cycle past the strobe; data lands two edges later.
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] val);
    put(1'b0, idx);
    @(negedge clk_in);
    addr_out = 1'b1;
    wr_out = 1'b0;
    rd_out = 1'b1;
    wdata_out = ~wdata_out;
    @(negedge clk_in);
    rd_out = 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    val = rdata_in;
    idle();
  endtask : read_reg
endmodule : fcr_host_model
`default_nettype wire

/* File: fcr_tb.sv */
// Self-checking bench for the floppy configuration register bank.
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); miscompares++; end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, sel, addr, wr, rd, enh, dma_nb, wp_out, dens_out;
  logic wp_in = 1'b0, dis_wp = 1'b0, core_dens = 1'b0;
  logic [1:0] if_mode, type_a, type_b;
  logic [3:0] core_n = 4'hF, pin, pin_oe_n;
  logic [7:0] wdata, rdata, v;
  int miscompares = 0, check_count = 0, cycles = 0;
  // ==========================================
  // Clock, design and host
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  fcr_floppy_cfg #(.DATA_W(8)) dut (.CLK_IN(clk), .SYS_RST_IN(sys_rst), .CFG_SEL_IN(sel),
    .CFG_ADDR_IN(addr), .CFG_WR_IN(wr), .CFG_RD_IN(rd), .CFG_WDATA_IN(wdata),
    .CFG_RDATA_OUT(rdata), .ENH_MODE_OUT(enh), .DMA_NON_BURST_OUT(dma_nb),
    .IF_MODE_OUT(if_mode), .DRIVE_A_TYPE_OUT(type_a), .DRIVE_B_TYPE_OUT(type_b),
    .WRITE_PROTECT_INPUT_IN(wp_in), .DISABLE_WP_IN(dis_wp), .CORE_WRITE_PROTECT_OUT(wp_out),
    .CORE_DENSITY_IN(core_dens), .DENSITY_OUT(dens_out),
    .CORE_DRIVE0_SELECT_LINE_N_IN(core_n[0]), .CORE_DRIVE1_SELECT_LINE_N_IN(core_n[1]),
    .CORE_MOTOR0_ON_LINE_N_IN(core_n[2]), .CORE_MOTOR1_ON_LINE_N_IN(core_n[3]),
    .DRIVE_PIN_OUT(pin), .DRIVE_PIN_OE_N_OUT(pin_oe_n));
  fcr_host_model host (.clk_in(clk), .sel_out(sel), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata));
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Cuts a hung run short well past the expected length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================
  // Scenarios
  // Holds the hard reset for the given number of cycles.
  task automatic do_reset(input int n);
    sys_rst = 1'b1;
    repeat (n) @(negedge clk);
    sys_rst = 1'b0;
  endtask : do_reset
  // Every register and control output shows its default value.
  task automatic check_defaults();
    logic [7:0] exp [4];
    exp = '{8'h0E, 8'h00, 8'hFF, 8'h00};
    for (int i = 0; i < 4; i++) begin
      host.read_reg(8'hF0 + 8'(i), v);
      `CHK("default", exp[i], v);
    end
    `CHK("enh", 1'b0, enh);
    `CHK("dma", 1'b1, dma_nb);
    `CHK("ifm", 2'b11, if_mode);
    `CHK("types", 4'hF, {type_b, type_a});
  endtask : check_defaults
  // Walks all interface codes while toggling both mode bits below them.
  task automatic mode_fields();
    logic [1:0] k;
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      host.write_reg(8'hF0, {4'h0, k, k[0], ~k[0]});
      `CHK("ifm", k, if_mode);
      `CHK("enh", ~k[0], enh);
      `CHK("dma", k[0], dma_nb);
    end
  endtask : mode_fields
  // Exchange, driver style and float of the drive lines.
  task automatic drive_lines();
    logic [7:0] md [4];
    logic [3:0] ep [4];
    logic [3:0] eo [4];
    md = '{8'h0E, 8'h1E, 8'h5E, 8'h8E};
    ep = '{4'b1010, 4'b0101, 4'b0101, 4'b1010};
    eo = '{4'b1010, 4'b0101, 4'b0000, 4'b1111};
    core_n = 4'b1010;
    for (int i = 0; i < 4; i++) begin
      host.write_reg(8'hF0, md[i]);
      `CHK("pins", ep[i], pin);
      `CHK("oe_n", eo[i], pin_oe_n);
    end
  endtask : drive_lines
  // All sixteen input combinations with forced protect off and on.
  task automatic write_protect();
    for (int f = 0; f < 2; f++) begin
      host.write_reg(8'hF1, 8'(f));
      for (int j = 0; j < 16; j++) begin
        @(negedge clk);
        {dis_wp, wp_in, core_n[1:0]} = 4'(j);
        @(posedge clk);
        `CHK("wp", (f[0] & ~&core_n[1:0]) | wp_in | dis_wp, wp_out);
      end
    end
    {dis_wp, wp_in} = 2'b00;
  endtask : write_protect
  // Every density code against both core density levels.
  task automatic density();
    logic [1:0] k;
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      host.write_reg(8'hF1, {4'h0, k, 2'b00});
      for (int d = 0; d < 2; d++) begin
        @(negedge clk);
        core_dens = d[0];
        @(posedge clk);
        `CHK("dens", k[1] ? ~k[0] : d[0], dens_out);
      end
    end
  endtask : density
  // Spare bits store, the zero register and an unmapped index refuse writes.
  task automatic store_and_refuse();
    host.write_reg(8'hF2, 8'h36);
    `CHK("types", 4'b0110, {type_b, type_a});
    host.write_reg(8'hF1, 8'hA2);
    host.read_reg(8'hF1, v);
    `CHK("option", 8'hA2, v);
    `CHK("dens", core_dens, dens_out);
    host.write_reg(8'hF3, 8'h5A);
    host.write_reg(8'h70, 8'hFF);
    host.read_reg(8'hF3, v);
    `CHK("zero", 8'h00, v);
    host.read_reg(8'h70, v);
    `CHK("unmapped", 8'h00, v);
    host.read_reg(8'hF2, v);
    `CHK("type", 8'h36, v);
  endtask : store_and_refuse
  // Main sequence, ending with a mid-run hard reset.
  initial begin
    sys_rst = 1'b1;
    do_reset(12);
    check_defaults();
    mode_fields();
    drive_lines();
    write_protect();
    density();
    store_and_refuse();
    @(negedge clk);
    do_reset(2);
    check_defaults();
    final_report();
  end
endmodule : tb
`default_nettype wire
